// file: rtl/pasl_strap_led.sv
// Overview of operation
// R1: Pins are strap inputs during hardware reset
// R2: Sampled low gives zero, high one
// R3: After reset pins become status outputs
// R4: Bit 0 pin shows receive or transmit activity
// R5: Bit 1 pin pulses about 70 ms per collision
// R6: Bit 2 pin shows valid link
// R7: Bit 3 pin shows transmit activity
// R8: Board pulls every strap pin up or down
// R9: Asserted output level inverts sampled strap level
// R10: Software reset keeps pins outputs, no resample
// R11: Collision during hold restarts the interval
`timescale 1ns/1ns
`default_nettype none

module pasl_strap_led
  import pasl_pkg::*;
#(
  parameter int unsigned COL_HOLD_CYC = PASL_COL_HOLD_CYC
)(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [PASL_PINS-1:0] strap_pin_in,
  input wire logic rx_active_in,
  input wire logic tx_active_in,
  input wire logic link_valid_in,
  input wire logic collision_in,
  input wire logic soft_reset_in,
  output logic [PASL_PINS-1:0] strap_pin_out,
  output logic [PASL_PINS-1:0] strap_pin_oe_out,
  output logic [PASL_PINS-1:0] station_mgmt_address_out
);

  // Registered state and its next value
  pasl_state_t s_q;
  pasl_state_t s_d;

  // Synchronised status inputs
  logic col_seen;
  logic rx_seen;
  logic tx_seen;

  // Collision hold timer helpers
  logic col_busy;
  logic [PASL_CNT_W-1:0] hold_load;
  logic [PASL_CNT_W-1:0] hold_dec;

  // Status indications and pin drive levels
  wire logic [PASL_PINS-1:0] status;
  wire logic [PASL_PINS-1:0] drive_val;

  // Taps of the second synchroniser stage
  assign col_seen = s_q.rx_s2[PASL_SYNC_COL];
  assign rx_seen = s_q.rx_s2[PASL_SYNC_RX];
  assign tx_seen = s_q.rx_s2[PASL_SYNC_TX];

  // Hold timer is busy while any count remains
  assign col_busy = (s_q.col_cnt != PASL_CNT_ZERO);
  assign hold_load = PASL_CNT_W'(COL_HOLD_CYC - 1);
  assign hold_dec = s_q.col_cnt - PASL_CNT_ONE;

  // Per pin status and drive level
  for (genvar i = 0; i < PASL_PINS; i++)
  begin : g_pin
    if (i == PASL_BIT_ACT)
    begin : g_act
      assign status[i] = rx_seen | tx_seen; // R4
    end
    else if (i == PASL_BIT_COL)
    begin : g_col
      assign status[i] = col_seen | col_busy; // R5
    end
    else if (i == PASL_BIT_LINK)
    begin : g_link
      assign status[i] = link_valid_in; // R6
    end
    else
    begin : g_tx
      assign status[i] = tx_seen; // R7
    end

    // Asserted level is the inverse of the strapped level
    assign drive_val[i] = s_q.addr[i] ^ status[i]; // R9
  end

  always_comb
  begin
    s_d = s_q;

    // Two-stage synchronisers on the strap pins
    s_d.strap_s1 = strap_pin_in;
    s_d.strap_s2 = s_q.strap_s1;

    // Two-stage synchronisers on the collision, receive and transmit inputs
    s_d.rx_s1[PASL_SYNC_COL] = collision_in;
    s_d.rx_s1[PASL_SYNC_RX] = rx_active_in;
    s_d.rx_s1[PASL_SYNC_TX] = tx_active_in;
    s_d.rx_s2 = s_q.rx_s1;

    // Collision hold timer, reloaded by every collision
    if (col_seen)
    begin
      s_d.col_cnt = hold_load; // R11
    end
    else if (col_busy)
    begin
      s_d.col_cnt = hold_dec; // R5
    end
    else
    begin
      s_d.col_cnt = PASL_CNT_ZERO;
    end

    // Pin direction and station address
    case (s_q.phase)
      PASL_SAMPLE:
      begin
        s_d.addr = s_q.strap_s2; // R1 R2
        s_d.pin_oe = '1; // R3
        s_d.pin_o = s_q.strap_s2; // R9
        s_d.phase = PASL_DRIVE; // R3
      end
      PASL_DRIVE:
      begin
        s_d.addr = s_q.addr;
        s_d.pin_oe = '1; // R3
        s_d.pin_o = drive_val; // R4 R5 R6 R7
        s_d.phase = PASL_DRIVE;
        if (soft_reset_in)
        begin
          s_d.addr = s_q.addr; // R10
          s_d.pin_oe = '1; // R10
        end
      end
      default:
      begin
        s_d.addr = PASL_ADDR_RST;
        s_d.pin_oe = '0;
        s_d.pin_o = '0;
        s_d.phase = PASL_SAMPLE;
      end
    endcase

    // Hardware reset releases the pins; straps keep filling the synchroniser
    if (!resetn_in)
    begin
      s_d.phase = PASL_SAMPLE; // R1
      s_d.addr = PASL_ADDR_RST;
      s_d.pin_o = '0;
      s_d.pin_oe = '0; // R1
      s_d.rx_s1 = '0;
      s_d.rx_s2 = '0;
      s_d.col_cnt = PASL_CNT_ZERO;
    end
  end

  always_ff @(posedge clk_in)
  begin
    s_q <= s_d;
  end

  // Outputs come straight from the state register
  assign strap_pin_out = s_q.pin_o;
  assign strap_pin_oe_out = s_q.pin_oe;
  assign station_mgmt_address_out = s_q.addr;
endmodule // pasl_strap_led
`default_nettype wire

// file: rtl/pasl_pkg.sv
package pasl_pkg;
  localparam int unsigned PASL_PINS = 4;
  localparam int unsigned PASL_CLK_HZ = 20000000;
  localparam int unsigned PASL_COL_HOLD_MS = 70;
  localparam int unsigned PASL_COL_HOLD_CYC = PASL_COL_HOLD_MS * (PASL_CLK_HZ / 1000);
  localparam int unsigned PASL_CNT_W = 21;
  localparam int unsigned PASL_BIT_ACT = 0;
  localparam int unsigned PASL_BIT_COL = 1;
  localparam int unsigned PASL_BIT_LINK = 2;
  localparam int unsigned PASL_BIT_TX = 3;
  localparam int unsigned PASL_SYNC_W = 3;
  localparam int unsigned PASL_SYNC_TX = 0;
  localparam int unsigned PASL_SYNC_RX = 1;
  localparam int unsigned PASL_SYNC_COL = 2;
  localparam logic [PASL_PINS-1:0] PASL_ADDR_RST = 4'h0;
  localparam logic [PASL_CNT_W-1:0] PASL_CNT_ZERO = 21'h000000;
  localparam logic [PASL_CNT_W-1:0] PASL_CNT_ONE = 21'h000001;

  typedef enum logic [0:0] {PASL_SAMPLE, PASL_DRIVE} pasl_phase_t;

  typedef struct packed {
    pasl_phase_t phase;
    logic [PASL_PINS-1:0] strap_s1;
    logic [PASL_PINS-1:0] strap_s2;
    logic [PASL_PINS-1:0] addr;
    logic [PASL_PINS-1:0] pin_o;
    logic [PASL_PINS-1:0] pin_oe;
    logic [PASL_SYNC_W-1:0] rx_s1;
    logic [PASL_SYNC_W-1:0] rx_s2;
    logic [PASL_CNT_W-1:0] col_cnt;
  } pasl_state_t;
endpackage

// file: tb/pasl_brd.sv
`timescale 1ns/1ns
`default_nettype none
module pasl_brd #(parameter logic [3:0] STRAP = 4'h5) (
  input wire logic [3:0] oe_in,
  input wire logic [3:0] drv_in,
  output logic [3:0] pin_out
);
  assign pin_out = (oe_in & drv_in) | (~oe_in & STRAP);
endmodule // pasl_brd
`default_nettype wire

// file: tb/pasl_strap_led_chk.sv
`timescale 1ns/1ns
`default_nettype none
module pasl_strap_led_chk (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic rx_active_in,
  input wire logic tx_active_in,
  input wire logic link_valid_in,
  input wire logic collision_in,
  input wire logic [3:0] strap_pin_in,
  input wire logic [3:0] strap_pin_out,
  input wire logic [3:0] strap_pin_oe_out,
  input wire logic [3:0] station_mgmt_address_out
);
  default clocking @(posedge clk_in); endclocking
  sequence s_run2; resetn_in[*2]; endsequence
  sequence s_run3; resetn_in[*3]; endsequence
  property p_oe; !resetn_in |=> strap_pin_oe_out == 4'h0; endproperty
  a_oe: assert property (p_oe) else $error("pin driven in reset");
  property p_adr; disable iff (!resetn_in) $rose(resetn_in) |=>
    station_mgmt_address_out == $past(strap_pin_in, 3); endproperty
  a_adr: assert property (p_adr) else $error("address not sampled");
  property p_out; disable iff (!resetn_in) s_run3 |->
    $stable(station_mgmt_address_out) && &strap_pin_oe_out; endproperty
  a_out: assert property (p_out) else $error("pins not held outputs");
  property p_lnk; disable iff (!resetn_in) s_run2 |=>
    strap_pin_out[2] == (station_mgmt_address_out[2] ^ $past(link_valid_in)); endproperty
  a_lnk: assert property (p_lnk) else $error("link pin wrong");
  property p_act; disable iff (!resetn_in) s_run3 |=> strap_pin_out[0] ==
    (station_mgmt_address_out[0] ^ ($past(rx_active_in, 3) | $past(tx_active_in, 3)));
  endproperty
  a_act: assert property (p_act) else $error("activity pin wrong");
  property p_tx; disable iff (!resetn_in) s_run3 |=>
    strap_pin_out[3] == (station_mgmt_address_out[3] ^ $past(tx_active_in, 3)); endproperty
  a_tx: assert property (p_tx) else $error("transmit pin wrong");
  property p_col; disable iff (!resetn_in) s_run3 ##0 $past(collision_in, 2) |=>
    strap_pin_out[1] != station_mgmt_address_out[1]; endproperty
  a_col: assert property (p_col) else $error("collision pin not asserted");
endmodule // pasl_strap_led_chk
bind pasl_strap_led pasl_strap_led_chk chk (
  .clk_in(clk_in),
  .resetn_in(resetn_in),
  .rx_active_in(rx_active_in),
  .tx_active_in(tx_active_in),
  .link_valid_in(link_valid_in),
  .collision_in(collision_in),
  .strap_pin_in(strap_pin_in),
  .strap_pin_out(strap_pin_out),
  .strap_pin_oe_out(strap_pin_oe_out),
  .station_mgmt_address_out(station_mgmt_address_out)
);
`default_nettype wire

// file: tb/pasl_strap_led_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module pasl_strap_led_tb_top;
  logic clk_in = 1'h0;
  logic resetn_in = 1'h0;
  logic rx = 1'h0;
  logic tx = 1'h0;
  logic lk = 1'h0;
  logic col = 1'h0;
  logic sr = 1'h0;
  logic [3:0] po;
  logic [3:0] oe;
  logic [3:0] ad;
  logic [3:0] pin;
  int miscompares = 0;
  int num_checks = 0;
  always #25 clk_in = ~clk_in;
  pasl_brd #(.STRAP(4'h5)) brd (.oe_in(oe), .drv_in(po), .pin_out(pin));
  pasl_strap_led #(.COL_HOLD_CYC(20)) dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .strap_pin_in(pin), .rx_active_in(rx), .tx_active_in(tx), .link_valid_in(lk),
    .collision_in(col), .soft_reset_in(sr), .strap_pin_out(po), .strap_pin_oe_out(oe),
    .station_mgmt_address_out(ad));
  task automatic cmp(string n, logic [3:0] e, logic [3:0] s);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_in);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic t_hw_reset;
    resetn_in = 1'h0;
    cyc(10);
    cmp("reset oe", 4'h0, oe);
    cmp("reset addr", 4'h0, ad);
    cmp("reset pin", 4'h5, pin);
    resetn_in = 1'h1;
    cyc(1);
    cmp("addr", 4'h5, ad);
    cmp("oe", 4'hf, oe);
    cmp("idle", 4'h5, pin);
  endtask
  task automatic t_status;
    lk = 1'h1;
    tx = 1'h1;
    cyc(4);
    cmp("tx link", 4'h8, pin);
    tx = 1'h0;
    rx = 1'h1;
    cyc(4);
    cmp("rx link", 4'h0, pin);
    rx = 1'h0;
    lk = 1'h0;
    cyc(4);
    cmp("quiet", 4'h5, pin);
  endtask
  task automatic t_collision;
    col = 1'h1;
    cyc(1);
    col = 1'h0;
    cyc(10);
    col = 1'h1;
    cyc(1);
    col = 1'h0;
    cyc(15);
    cmp("col held", 4'h7, pin);
    cyc(15);
    cmp("col end", 4'h5, pin);
  endtask
  task automatic t_soft;
    sr = 1'h1;
    tx = 1'h1;
    cyc(4);
    cmp("soft oe", 4'hf, oe);
    cmp("soft addr", 4'h5, ad);
    cmp("soft pin", 4'hc, pin);
    sr = 1'h0;
    tx = 1'h0;
    cyc(4);
    cmp("soft end", 4'h5, pin);
  endtask
  initial
  begin
    t_hw_reset();
    t_status();
    t_collision();
    t_soft();
    t_hw_reset();
    t_status();
    finish_test();
  end
endmodule // pasl_strap_led_tb_top
`default_nettype wire
